//--- design/gpio_de_pkg.sv
// Purpose: shared constants for the port D / port E pin block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   register byte address is four times the register index
package gpio_de_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned PORT_W = 8;

    // register indices; byte address = index * 4
    localparam logic [ADDR_W-1:0] IDX_PORT_D_DATA      = 8'h03;
    localparam logic [ADDR_W-1:0] IDX_PORT_D_DIRECTION = 8'h07;
    localparam logic [ADDR_W-1:0] IDX_PORT_E_DATA      = 8'h08;
    localparam logic [ADDR_W-1:0] IDX_PORT_E_DIRECTION = 8'h0c;
    localparam logic [ADDR_W-1:0] IDX_PIN_FUNCTION     = 8'h10;

    localparam logic [ADDR_W-1:0] ADDR_PORT_D_DATA      = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_PORT_D_DIRECTION = 8'h1c;
    localparam logic [ADDR_W-1:0] ADDR_PORT_E_DATA      = 8'h20;
    localparam logic [ADDR_W-1:0] ADDR_PORT_E_DIRECTION = 8'h30;
    localparam logic [ADDR_W-1:0] ADDR_PIN_FUNCTION     = 8'h40;

    localparam logic [PORT_W-1:0] DIRECTION_RESET = 8'h00;

    // pin function register layout
    localparam int unsigned FN_W            = 14;
    localparam int unsigned FN_TA_PSC_LSB   = 0;
    localparam int unsigned FN_TB_PSC_LSB   = 3;
    localparam int unsigned FN_SP_ENABLE    = 6;
    localparam int unsigned FN_SP_MASTER    = 7;
    localparam int unsigned FN_MODE_FAULT   = 8;
    localparam int unsigned FN_ELS0_LSB     = 9;
    localparam int unsigned FN_ELS1_LSB     = 11;
    localparam int unsigned FN_ASYNC_ENABLE = 13;
    localparam logic [FN_W-1:0] FN_RESET    = 14'h0000;

    localparam int unsigned PSC_W = 3;
    localparam int unsigned ELS_W = 2;
    // prescaler code that routes the external pin clock to a timer
    localparam logic [PSC_W-1:0] PSC_EXT_CLOCK = 3'h7;
    localparam logic [ELS_W-1:0] ELS_PIN_OFF = 2'h0;

    // pin positions
    localparam int unsigned PD_TIMER_A_CLK = 6;
    localparam int unsigned PD_TIMER_B_CLK = 4;
    localparam int unsigned PE_SCK  = 7;
    localparam int unsigned PE_MOSI = 6;
    localparam int unsigned PE_MISO = 5;
    localparam int unsigned PE_SS   = 4;
    localparam int unsigned PE_CH1  = 3;
    localparam int unsigned PE_CH0  = 2;
    localparam int unsigned PE_RXD  = 1;
    localparam int unsigned PE_TXD  = 0;

endpackage

//--- design/gpio_ports_d_e.sv
// Purpose: port D and port E pin logic with peripheral sharing, APB regs
// Assumes: peripherals run on ref_clk; pins pass two flops before use
// Notes:   pin muxing is combinational from the function register
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module gpio_ports_d_e #(
    parameter int unsigned PORT_W = gpio_de_pkg::PORT_W
) (
    input  wire logic                           ref_clk,
    input  wire logic                           rst_n,
    // apb slave
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [gpio_de_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                    pwdata,
    output logic      [31:0]                    prdata,
    output logic                                pready,
    output logic                                pslverr,
    // pins
    input  wire logic [PORT_W-1:0]              port_d_pin_in,
    output logic      [PORT_W-1:0]              port_d_pin_out,
    output logic      [PORT_W-1:0]              port_d_pin_oe_n,
    input  wire logic [PORT_W-1:0]              port_e_pin_in,
    output logic      [PORT_W-1:0]              port_e_pin_out,
    output logic      [PORT_W-1:0]              port_e_pin_oe_n,
    // control bits handed to the peripherals
    output logic      [gpio_de_pkg::PSC_W-1:0]  timer_a_prescaler_select,
    output logic      [gpio_de_pkg::PSC_W-1:0]  timer_b_prescaler_select,
    output logic                                serial_periph_enable,
    output logic                                serial_periph_master_sel,
    output logic                                mode_fault_enable,
    output logic      [gpio_de_pkg::ELS_W-1:0]  edge_level_select0,
    output logic      [gpio_de_pkg::ELS_W-1:0]  edge_level_select1,
    output logic                                async_serial_enable,
    // timer side
    output logic                                timer_a_ext_clock,
    output logic                                timer_b_ext_clock,
    input  wire logic [1:0]                     timer_a_channel_out,
    input  wire logic [1:0]                     timer_a_channel_drive,
    output logic      [1:0]                     timer_a_channel_in,
    // serial peripheral side
    input  wire logic                           serial_periph_clock_out,
    output logic                                serial_periph_clock_in,
    input  wire logic                           serial_periph_mosi_out,
    output logic                                serial_periph_mosi_in,
    input  wire logic                           serial_periph_miso_out,
    output logic                                serial_periph_miso_in,
    output logic                                serial_periph_ss_in,
    // async serial side
    input  wire logic                           async_serial_txd,
    output logic                                async_serial_rxd
);

    logic [PORT_W-1:0]            port_d_data_q;
    logic [PORT_W-1:0]            port_d_direction_q;
    logic [PORT_W-1:0]            port_e_data_q;
    logic [PORT_W-1:0]            port_e_direction_q;
    logic [gpio_de_pkg::FN_W-1:0] pin_function_q;
    logic [31:0]                  prdata_q;
    logic [PORT_W-1:0]            port_d_sync;
    logic [PORT_W-1:0]            port_e_sync;

    pin_sync #(
        .WIDTH    (PORT_W)
    ) u_sync_d (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .async_in (port_d_pin_in),
        .sync_out (port_d_sync)
    );

    pin_sync #(
        .WIDTH    (PORT_W)
    ) u_sync_e (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .async_in (port_e_pin_in),
        .sync_out (port_e_sync)
    );

    // address decode
    wire setup_phase  = psel & ~penable;
    wire access_phase = psel & penable;
    wire hit_d_data   = (paddr == gpio_de_pkg::ADDR_PORT_D_DATA);
    wire hit_d_dir    = (paddr == gpio_de_pkg::ADDR_PORT_D_DIRECTION);
    wire hit_e_data   = (paddr == gpio_de_pkg::ADDR_PORT_E_DATA);
    wire hit_e_dir    = (paddr == gpio_de_pkg::ADDR_PORT_E_DIRECTION);
    wire hit_fn       = (paddr == gpio_de_pkg::ADDR_PIN_FUNCTION);
    wire addr_hit     = hit_d_data | hit_d_dir | hit_e_data | hit_e_dir
                      | hit_fn;
    wire wr_en        = access_phase & pwrite & addr_hit;
    wire wr_d_data    = wr_en & hit_d_data;
    wire wr_d_dir     = wr_en & hit_d_dir;
    wire wr_e_data    = wr_en & hit_e_data;
    wire wr_e_dir     = wr_en & hit_e_dir;
    wire wr_fn        = wr_en & hit_fn;

    // zero wait states; unmapped addresses answer with an error
    assign pready  = access_phase;
    assign pslverr = access_phase & ~addr_hit;
    assign prdata  = prdata_q;

    // function register fields
    wire [gpio_de_pkg::PSC_W-1:0] psc_a =
        pin_function_q[gpio_de_pkg::FN_TA_PSC_LSB +: gpio_de_pkg::PSC_W];
    wire [gpio_de_pkg::PSC_W-1:0] psc_b =
        pin_function_q[gpio_de_pkg::FN_TB_PSC_LSB +: gpio_de_pkg::PSC_W];
    wire [gpio_de_pkg::ELS_W-1:0] els0 =
        pin_function_q[gpio_de_pkg::FN_ELS0_LSB +: gpio_de_pkg::ELS_W];
    wire [gpio_de_pkg::ELS_W-1:0] els1 =
        pin_function_q[gpio_de_pkg::FN_ELS1_LSB +: gpio_de_pkg::ELS_W];
    wire sp_en   = pin_function_q[gpio_de_pkg::FN_SP_ENABLE];
    wire sp_mstr = pin_function_q[gpio_de_pkg::FN_SP_MASTER];
    wire mf_en   = pin_function_q[gpio_de_pkg::FN_MODE_FAULT];
    wire as_en   = pin_function_q[gpio_de_pkg::FN_ASYNC_ENABLE];

    assign timer_a_prescaler_select = psc_a;
    assign timer_b_prescaler_select = psc_b;
    assign serial_periph_enable     = sp_en;
    assign serial_periph_master_sel = sp_mstr;
    assign mode_fault_enable        = mf_en;
    assign edge_level_select0       = els0;
    assign edge_level_select1       = els1;
    assign async_serial_enable      = as_en;

    // port D: timer clock pins
    wire ta_ext_sel = (psc_a == gpio_de_pkg::PSC_EXT_CLOCK);
    wire tb_ext_sel = (psc_b == gpio_de_pkg::PSC_EXT_CLOCK);

    logic [PORT_W-1:0] port_d_taken;
    always_comb
    begin
        port_d_taken = '0;
        port_d_taken[gpio_de_pkg::PD_TIMER_A_CLK] = ta_ext_sel;
        port_d_taken[gpio_de_pkg::PD_TIMER_B_CLK] = tb_ext_sel;
    end

    // taken pins are inputs whatever the direction bit
    wire [PORT_W-1:0] port_d_drive =
        port_d_direction_q & ~port_d_taken;
    assign port_d_pin_out  = port_d_data_q;
    assign port_d_pin_oe_n = ~port_d_drive;

    assign timer_a_ext_clock = port_d_sync[gpio_de_pkg::PD_TIMER_A_CLK];
    assign timer_b_ext_clock = port_d_sync[gpio_de_pkg::PD_TIMER_B_CLK];

    // taken pins with direction clear read zero rather than the pin
    wire [PORT_W-1:0] port_d_read =
        (port_d_direction_q & port_d_data_q)
      | (~port_d_direction_q & ~port_d_taken & port_d_sync);

    // port E: which pins a peripheral owns
    wire ss_used  = sp_en & ~(sp_mstr & ~mf_en);
    wire ch0_used = (els0 != gpio_de_pkg::ELS_PIN_OFF);
    wire ch1_used = (els1 != gpio_de_pkg::ELS_PIN_OFF);

    logic [PORT_W-1:0] port_e_taken;
    logic [PORT_W-1:0] port_e_periph_drive;
    logic [PORT_W-1:0] port_e_periph_value;
    always_comb
    begin
        port_e_taken        = '0;
        port_e_periph_drive = '0;
        port_e_periph_value = '0;
        // serial clock follows master select
        port_e_taken[gpio_de_pkg::PE_SCK]        = sp_en;
        port_e_periph_drive[gpio_de_pkg::PE_SCK] = sp_en & sp_mstr;
        port_e_periph_value[gpio_de_pkg::PE_SCK] = serial_periph_clock_out;
        port_e_taken[gpio_de_pkg::PE_MOSI]        = sp_en;
        port_e_periph_drive[gpio_de_pkg::PE_MOSI] = sp_en & sp_mstr;
        port_e_periph_value[gpio_de_pkg::PE_MOSI] = serial_periph_mosi_out;
        port_e_taken[gpio_de_pkg::PE_MISO]        = sp_en;
        port_e_periph_drive[gpio_de_pkg::PE_MISO] = sp_en & ~sp_mstr;
        port_e_periph_value[gpio_de_pkg::PE_MISO] = serial_periph_miso_out;
        // slave select is an input whenever the serial peripheral owns it
        port_e_taken[gpio_de_pkg::PE_SS] = ss_used;
        port_e_taken[gpio_de_pkg::PE_CH1]        = ch1_used;
        port_e_periph_drive[gpio_de_pkg::PE_CH1] =
            ch1_used & timer_a_channel_drive[1];
        port_e_periph_value[gpio_de_pkg::PE_CH1] = timer_a_channel_out[1];
        port_e_taken[gpio_de_pkg::PE_CH0]        = ch0_used;
        port_e_periph_drive[gpio_de_pkg::PE_CH0] =
            ch0_used & timer_a_channel_drive[0];
        port_e_periph_value[gpio_de_pkg::PE_CH0] = timer_a_channel_out[0];
        port_e_taken[gpio_de_pkg::PE_RXD] = as_en;
        port_e_taken[gpio_de_pkg::PE_TXD]        = as_en;
        port_e_periph_drive[gpio_de_pkg::PE_TXD] = as_en;
        port_e_periph_value[gpio_de_pkg::PE_TXD] = async_serial_txd;
    end

    // direction bits only set the drivers on pins no peripheral owns
    wire [PORT_W-1:0] port_e_drive =
        (port_e_taken & port_e_periph_drive)
      | (~port_e_taken & port_e_direction_q);
    assign port_e_pin_out =
        (port_e_taken & port_e_periph_value)
      | (~port_e_taken & port_e_data_q);
    assign port_e_pin_oe_n = ~port_e_drive;

    // reads pick latch or pin even on peripheral pins
    wire [PORT_W-1:0] port_e_read =
        (port_e_direction_q & port_e_data_q)
      | (~port_e_direction_q & port_e_sync);

    assign serial_periph_clock_in = port_e_sync[gpio_de_pkg::PE_SCK];
    assign serial_periph_mosi_in  = port_e_sync[gpio_de_pkg::PE_MOSI];
    assign serial_periph_miso_in  = port_e_sync[gpio_de_pkg::PE_MISO];
    assign serial_periph_ss_in    = port_e_sync[gpio_de_pkg::PE_SS];
    assign timer_a_channel_in     =
        port_e_sync[gpio_de_pkg::PE_CH0 +: 2];
    assign async_serial_rxd       = port_e_sync[gpio_de_pkg::PE_RXD];

    // read mux
    logic [31:0] read_value;
    always_comb
    begin
        read_value = 32'h0000_0000;
        if (hit_d_data)
            read_value[PORT_W-1:0] = port_d_read;
        else if (hit_d_dir)
            read_value[PORT_W-1:0] = port_d_direction_q;
        else if (hit_e_data)
            read_value[PORT_W-1:0] = port_e_read;
        else if (hit_e_dir)
            read_value[PORT_W-1:0] = port_e_direction_q;
        else if (hit_fn)
            read_value[gpio_de_pkg::FN_W-1:0] = pin_function_q;
    end

    // read data captured in the setup cycle, held through access
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            prdata_q <= 32'h0000_0000;
        else if (setup_phase && !pwrite)
            prdata_q <= read_value;
    end

    // data latches have no reset: contents survive a reset
    always_ff @(posedge ref_clk)
    begin
        if (wr_d_data)
            port_d_data_q <= pwdata[PORT_W-1:0];
        if (wr_e_data)
            port_e_data_q <= pwdata[PORT_W-1:0];
    end

    // writing data before direction avoids a glitch; software's job
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            port_d_direction_q <= gpio_de_pkg::DIRECTION_RESET;
            port_e_direction_q <= gpio_de_pkg::DIRECTION_RESET;
            pin_function_q     <= gpio_de_pkg::FN_RESET;
        end
        else
        begin
            if (wr_d_dir)
                port_d_direction_q <= pwdata[PORT_W-1:0];
            if (wr_e_dir)
                port_e_direction_q <= pwdata[PORT_W-1:0];
            if (wr_fn)
                pin_function_q <= pwdata[gpio_de_pkg::FN_W-1:0];
        end
    end

endmodule
`default_nettype wire

//--- design/pin_sync.sv
// Purpose: two-stage synchroniser for a bus of pin levels
// Assumes: pins are asynchronous to ref_clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule
`default_nettype wire

//--- tb/gpio_de_chk.sv
// Purpose: concurrent checks on pin ownership, direction and APB answer
// Assumes: zero wait APB; function bits as laid out in the package
// Notes:   peripheral pins are checked in the cycle the control bit holds
`timescale 1ns/1ps
`default_nettype none
module gpio_de_chk (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [7:0]  port_d_pin_out,
    input wire logic [7:0]  port_d_pin_oe_n,
    input wire logic [7:0]  port_e_pin_out,
    input wire logic [7:0]  port_e_pin_oe_n,
    input wire logic [2:0]  timer_a_prescaler_select,
    input wire logic [2:0]  timer_b_prescaler_select,
    input wire logic        serial_periph_enable,
    input wire logic        serial_periph_master_sel,
    input wire logic        mode_fault_enable,
    input wire logic [1:0]  edge_level_select0,
    input wire logic        async_serial_enable,
    input wire logic [1:0]  timer_a_channel_drive,
    input wire logic        serial_periph_clock_out,
    input wire logic        serial_periph_mosi_out,
    input wire logic        serial_periph_miso_out,
    input wire logic        async_serial_txd
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    wire sp_m = serial_periph_enable && serial_periph_master_sel;
    wire sp_s = serial_periph_enable && !serial_periph_master_sel;
    wire mapped = paddr inside {8'h0c, 8'h1c, 8'h20, 8'h30, 8'h40};

    sequence apb_wr(logic [7:0] a);
        psel && penable && pwrite && paddr == a;
    endsequence

    sequence apb_setup_access;
        psel && !penable ##1 psel && penable;
    endsequence

    apb_answer_a: assert property (apb_setup_access
        |-> pready && pslverr == !mapped) else $error("apb answer wrong");
    dir_drive_a: assert property (apb_wr(8'h1c) |=>
        port_d_pin_oe_n[3:0] == ~$past(pwdata[3:0]))
        else $error("port d drivers do not follow direction");
    latch_any_a: assert property (apb_wr(8'h0c) |=>
        port_d_pin_out == $past(pwdata[7:0])) else $error("latch not written");
    reset_inputs_a: assert property ($rose(rst_n) |->
        port_d_pin_oe_n == 8'hff && port_e_pin_oe_n == 8'hff)
        else $error("pins not inputs after reset");
    clk_pin_a: assert property (timer_a_prescaler_select == 3'h7 |->
        port_d_pin_oe_n[6]) else $error("timer a clock pin driven");
    clk_pin_b_a: assert property (timer_b_prescaler_select == 3'h7 |->
        port_d_pin_oe_n[4]) else $error("timer b clock pin driven");
    sck_master_a: assert property (sp_m |->
        port_e_pin_oe_n[7:6] == 2'h0 &&
        port_e_pin_out[7:6] == {serial_periph_clock_out,
        serial_periph_mosi_out}) else $error("master pins wrong");
    slave_pins_a: assert property (sp_s |->
        port_e_pin_oe_n[7:5] == 3'h6 &&
        port_e_pin_out[5] == serial_periph_miso_out)
        else $error("slave pins wrong");
    ss_input_a: assert property (serial_periph_enable &&
        !(serial_periph_master_sel && !mode_fault_enable)
        |-> port_e_pin_oe_n[4]) else $error("slave select driven");
    timer_ch_a: assert property (edge_level_select0 != 2'h0 |->
        port_e_pin_oe_n[2] == !timer_a_channel_drive[0])
        else $error("timer channel pin direction wrong");
    async_pins_a: assert property (async_serial_enable |->
        port_e_pin_oe_n[1:0] == 2'h2 && port_e_pin_out[0] == async_serial_txd)
        else $error("async serial pins wrong");
endmodule

bind gpio_ports_d_e gpio_de_chk gpio_de_chk_i (
    .ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .port_d_pin_out, .port_d_pin_oe_n, .port_e_pin_out,
    .port_e_pin_oe_n, .timer_a_prescaler_select, .timer_b_prescaler_select,
    .serial_periph_enable, .serial_periph_master_sel, .mode_fault_enable,
    .edge_level_select0, .async_serial_enable, .timer_a_channel_drive,
    .serial_periph_clock_out, .serial_periph_mosi_out,
    .serial_periph_miso_out, .async_serial_txd);
`default_nettype wire

//--- tb/gpio_ports_d_e_altfunc_bench.sv
// Purpose: self-checking bench for the port D / port E pin block
// Assumes: zero wait APB slave; two-flop pin synchronisers
// Notes:   port D cases are table rows; port E and reset cases follow
`timescale 1ns/1ps
`default_nettype none
module gpio_ports_d_e_altfunc_bench;
    typedef struct packed {
        logic [13:0] fn;
        logic [7:0]  dir, dat, ext, rd, oe;
        logic [1:0]  clk;
    } row_t;
    row_t rows [5] = '{
        '{14'h0000, 8'h00, 8'ha5, 8'h3c, 8'h3c, 8'hff, 2'h1},
        '{14'h0000, 8'hff, 8'ha5, 8'h00, 8'ha5, 8'h00, 2'h0},
        '{14'h0000, 8'h0f, 8'h96, 8'h5a, 8'h56, 8'hf0, 2'h3},
        '{14'h003f, 8'hff, 8'h5a, 8'h00, 8'h5a, 8'h50, 2'h0},
        '{14'h003f, 8'h00, 8'h5a, 8'hff, 8'haf, 8'hff, 2'h3}};
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdv;
    logic        pready, pslverr, errv, ta_clk, tb_clk, ss_in, rxd;
    logic        sck_in, mosi_in, miso_in;
    logic [1:0]  ch_in;
    logic [7:0]  d_in, d_out, d_oe_n, e_in, e_out, e_oe_n;
    logic [7:0]  d_val = 8'h00, d_en = 8'h00, e_val = 8'h12, e_en = 8'h00;
    logic [1:0]  ch_out = 2'h1, ch_drv = 2'h1;
    logic        sck_o = 1'b1, mosi_o = 1'b0, miso_o = 1'b1, txd = 1'b0;
    int          mismatches = 0;
    int          total_checks = 0;

    gpio_ports_d_e gpio_ports_d_e_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port_d_pin_in(d_in),
        .port_d_pin_out(d_out), .port_d_pin_oe_n(d_oe_n),
        .port_e_pin_in(e_in), .port_e_pin_out(e_out),
        .port_e_pin_oe_n(e_oe_n), .timer_a_prescaler_select(),
        .timer_b_prescaler_select(), .serial_periph_enable(),
        .serial_periph_master_sel(), .mode_fault_enable(),
        .edge_level_select0(), .edge_level_select1(),
        .async_serial_enable(), .timer_a_ext_clock(ta_clk),
        .timer_b_ext_clock(tb_clk), .timer_a_channel_out(ch_out),
        .timer_a_channel_drive(ch_drv), .timer_a_channel_in(ch_in),
        .serial_periph_clock_out(sck_o), .serial_periph_clock_in(sck_in),
        .serial_periph_mosi_out(mosi_o), .serial_periph_mosi_in(mosi_in),
        .serial_periph_miso_out(miso_o), .serial_periph_miso_in(miso_in),
        .serial_periph_ss_in(ss_in), .async_serial_txd(txd),
        .async_serial_rxd(rxd));
    pin_world pin_world_d (.ref_clk(ref_clk), .pin_out(d_out),
        .pin_oe_n(d_oe_n), .ext_val(d_val), .ext_en(d_en), .pin_in(d_in));
    pin_world pin_world_e (.ref_clk(ref_clk), .pin_out(e_out),
        .pin_oe_n(e_oe_n), .ext_val(e_val), .ext_en(e_en), .pin_in(e_in));

    initial
    begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one transfer; the slave sets the pace, a 20-cycle bound ends a stuck wait
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            check("pready", 32'h1, 32'h0);
            test_done();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check("prdata", exp, rdv);
    endtask

    initial
    begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        check("d_oe_n", 32'hff, {24'h0, d_oe_n});
        rd(gpio_de_pkg::ADDR_PORT_D_DIRECTION, 32'h0);
        rd(gpio_de_pkg::ADDR_PIN_FUNCTION, 32'h0);
        apb(1'b1, 8'h04, 32'hff);
        rd(8'h04, 32'h0);
        check("pslverr", 32'h1, {31'h0, errv});
        foreach (rows[i])
        begin
            d_val <= rows[i].ext;
            d_en <= rows[i].oe;
            apb(1'b1, gpio_de_pkg::ADDR_PIN_FUNCTION, {18'h0, rows[i].fn});
            apb(1'b1, gpio_de_pkg::ADDR_PORT_D_DATA,
                {24'h0, rows[i].dat});
            apb(1'b1, gpio_de_pkg::ADDR_PORT_D_DIRECTION,
                {24'h0, rows[i].dir});
            repeat (3) @(posedge ref_clk);
            check("d_oe_n", {24'h0, rows[i].oe}, {24'h0, d_oe_n});
            check("ext_clk", {30'h0, rows[i].clk},
                  {30'h0, ta_clk, tb_clk});
            rd(gpio_de_pkg::ADDR_PORT_D_DATA, {24'h0, rows[i].rd});
        end
        apb(1'b1, gpio_de_pkg::ADDR_PORT_E_DATA, 32'h3c);
        apb(1'b1, gpio_de_pkg::ADDR_PORT_D_DIRECTION, 32'hff);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(gpio_de_pkg::ADDR_PORT_D_DIRECTION, 32'h0);
        apb(1'b1, gpio_de_pkg::ADDR_PORT_E_DIRECTION, 32'hff);
        rd(gpio_de_pkg::ADDR_PORT_E_DATA, 32'h3c);
        apb(1'b1, gpio_de_pkg::ADDR_PORT_E_DATA, 32'h0);
        apb(1'b1, gpio_de_pkg::ADDR_PORT_E_DIRECTION, 32'h0);
        e_en <= 8'h3a;
        apb(1'b1, gpio_de_pkg::ADDR_PIN_FUNCTION, 32'h22c0);
        @(posedge ref_clk);
        check("e_oe_n", 32'h3a, {24'h0, e_oe_n});
        // owned pins carry the peripheral's value even while undriven
        check("e_out", 32'ha4, {24'h0, e_out});
        rd(gpio_de_pkg::ADDR_PORT_E_DATA, 32'h96);
        check("e_in_route", 32'h4b, {25'h0, sck_in, mosi_in, miso_in,
              ss_in, ch_in, rxd});
        apb(1'b1, gpio_de_pkg::ADDR_PORT_E_DIRECTION, 32'hff);
        rd(gpio_de_pkg::ADDR_PORT_E_DATA, 32'h0);
        // e4 and e3 have no owner here, so they follow the direction
        check("e_oe_n", 32'h22, {24'h0, e_oe_n});
        apb(1'b1, gpio_de_pkg::ADDR_PIN_FUNCTION, 32'h09c0);
        @(posedge ref_clk);
        check("e_oe_n", 32'h38, {24'h0, e_oe_n});
        e_en <= 8'hd0;
        apb(1'b1, gpio_de_pkg::ADDR_PIN_FUNCTION, 32'h0040);
        @(posedge ref_clk);
        check("e_oe_n", 32'hd0, {24'h0, e_oe_n});
        check("e_out", 32'ha0, {24'h0, e_out});
        apb(1'b1, gpio_de_pkg::ADDR_PIN_FUNCTION, 32'h0);
        @(posedge ref_clk);
        check("e_oe_n", 32'h0, {24'h0, e_oe_n});
        test_done();
    end
endmodule
`default_nettype wire

//--- tb/pin_world.sv
// Purpose: far side of the pins: board drivers and a floating wire
// Assumes: the block's driver wins over the board wherever both drive
// Notes:   an undriven, unpulled pin toggles every cycle
`timescale 1ns/1ps
`default_nettype none
module pin_world (
    input  wire logic       ref_clk,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe_n,
    input  wire logic [7:0] ext_val,
    input  wire logic [7:0] ext_en,
    output logic      [7:0] pin_in
);
    logic [7:0] float_q = 8'h55;

    // no pull on these pins, so a released pin must never look stable
    always_ff @(posedge ref_clk)
        float_q <= ~float_q;

    always_comb
        for (int i = 0; i < 8; i++)
            pin_in[i] = !pin_oe_n[i] ? pin_out[i] :
                        ext_en[i] ? ext_val[i] : float_q[i];
endmodule
`default_nettype wire
